// [design/pbtip_pkg.sv]
// pbtip_pkg: constants and types of the bus target/initiator port
`default_nettype none
package pbtip_pkg;
  // ****************************************
  // bus commands and configuration space
  // ****************************************
  localparam logic [3:0] CMD_MRD = 4'h6;
  localparam logic [3:0] CMD_MWR = 4'h7;
  localparam logic [3:0] CMD_CRD = 4'ha;
  localparam logic [3:0] CMD_CWR = 4'hb;
  localparam logic [5:0] CFG_ID = 6'h00;
  localparam logic [5:0] CFG_CMD = 6'h01; // byte offset 04h
  localparam logic [31:0] ID_VALUE = 32'h0001_0001; // arbitrary value
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] CMD_WMASK = 16'h0146;
  localparam logic [15:0] STS_RESET = 16'h0000;
  localparam int MEM_EN = 1;
  localparam int MST_EN = 2;
  localparam int PERR_EN = 6;
  localparam int SERR_EN = 8;
  localparam int ST_DPE = 15;
  localparam int ST_SSE = 14;
  localparam int ST_RMA = 13;
  localparam int ST_RTA = 12;
  localparam logic [27:0] MEM_BASE = 28'h0001000; // window base, ad[31:4]
  localparam int MEM_WORDS = 4;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 25;
  localparam int ABORT_NS = 125;
  localparam logic [2:0] ABORT_CLKS = 3'(ABORT_NS / CLK_NS);
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic perr_n;
  } pbtip_bus_t;
  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be_n;
  } pbtip_mreq_t;
  typedef enum logic [1:0] {
    RES_OK = 2'h0, RES_MABORT = 2'h1, RES_TABORT = 2'h2, RES_RETRY = 2'h3
  } pbtip_res_t;
  typedef enum logic [2:0] {
    T_IDLE = 3'h0, T_DEC = 3'h1, T_DATA = 3'h3, T_HOLD = 3'h2, T_TURN = 3'h6
  } pbtip_tst_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_REQ = 3'h1, M_ADDR = 3'h3, M_DATA = 3'h2, M_TURN = 3'h6
  } pbtip_mst_t;
endpackage : pbtip_pkg
`default_nettype wire

// [design/pbtip_port.sv]
// pbtip_port: primary bus target and initiator with parity and errors
`default_nettype none
// Function
// - ad carries address, then data
// - cbe carries command, then byte enables
// - byte enable n qualifies byte n
// - even parity over ad and cbe
// - initiator drives par one clock late
// - target flags received parity mismatch on perr
// - perr only when command bit 6 set
// - devsel claims decoded cycles
// - no devsel before timeout: master abort
// - frame high marks final data phase
// - phase completes only on irdy and trdy
// - req asks arbiter for the bus
// - idsel selects configuration accesses
// - serr pulses when command bit 8 set
// - card address parity error pulses serr
// - stop asks initiator to end transfer
// - all pins sampled on rising clock
// - reset releases pins, clears registers except the mem words
module pbtip_port
  import pbtip_pkg::*;
(
  input wire logic clk, // bus clock
  input wire logic pci_bus_reset, // synchronous, active high
  input wire pbtip_bus_t pins_i, // resolved bus levels
  output var pbtip_bus_t pins_o, // driven levels
  output var pbtip_bus_t pins_oe, // drive enables
  input wire logic idsel, // configuration select
  input wire logic gnt_n, // arbiter grant
  output logic req_n, // bus request
  output logic serr_o, // open-drain level, held low
  output logic serr_oe, // serr drive enable
  input wire logic cb_addr_perr, // card side address parity error
  input wire logic mst_start, // start one initiator transfer
  input wire pbtip_mreq_t mst_cmd, // transfer, valid with start
  output logic mst_busy, // initiator engaged
  output logic mst_done, // transfer finished pulse
  output pbtip_res_t mst_result, // outcome of last transfer
  output logic [31:0] mst_rdata // ad sampled at the end of the last completed transfer, read or write
);
  // ****************************************
  // decoding
  // ****************************************
  function automatic logic is_hit(input logic [31:0] ad, input logic [3:0] c,
                                  input logic sel, input logic mem_on);
    is_hit = ((c == CMD_CRD || c == CMD_CWR) && sel && ad[1:0] == 2'h0)
      || ((c == CMD_MRD || c == CMD_MWR) && mem_on && ad[31:4] == MEM_BASE);
  endfunction : is_hit

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be_n);
    merge_be = old;
    for (int b = 0; b < 4; b++) begin
      if (!be_n[b]) merge_be[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction : merge_be

  pbtip_tst_t t_st, next_t;
  pbtip_mst_t m_st, next_m;
  pbtip_mreq_t m_req, next_m_req;
  pbtip_bus_t next_o, next_oe;
  logic t_rd, next_t_rd, t_cfg, next_t_cfg, frame_d, addr_phase, t_rx, m_rx;
  logic [5:0] t_idx, next_t_idx;
  logic [15:0] cmd, next_cmd, sts, next_sts, sts_clr, sts_set;
  logic [31:0] t_rdata, next_t_rdata, wr_keep, wr_ones, next_rdata;
  logic [31:0] mem [MEM_WORDS];
  logic [31:0] next_mem [MEM_WORDS];
  logic [2:0] m_cnt, next_m_cnt;
  logic [3:0] cbe_bus;
  logic ev_dpe, ev_sse, ev_rma, ev_rta, next_done, bus_idle;
  pbtip_res_t next_res;
  logic dp_chk, next_dp_chk, dp_par, next_dp_par, ap_chk, next_ap_chk, ap_par;
  logic dp_bad, ap_bad, next_serr;
  logic [1:0] perr_ph, next_perr_ph;

  // own cycle excluded: it is never claimed by the local target
  assign addr_phase = !pins_i.frame_n && frame_d && m_st != M_ADDR;
  assign bus_idle = pins_i.frame_n && pins_i.irdy_n;
  assign wr_keep = merge_be({sts, cmd}, pins_i.ad, pins_i.cbe);
  assign wr_ones = merge_be(32'h0, pins_i.ad, pins_i.cbe);
  assign cbe_bus = pins_oe.cbe[0] ? pins_o.cbe : pins_i.cbe;

  // ****************************************
  // target and configuration registers
  // ****************************************
  always_comb begin
    next_t = t_st;
    next_t_rd = t_rd;
    next_t_cfg = t_cfg;
    next_t_idx = t_idx;
    next_t_rdata = t_rdata;
    next_cmd = cmd;
    next_mem = mem;
    sts_clr = 16'h0000;
    t_rx = 1'b0;
    case (t_st)
      T_IDLE: begin
        if (addr_phase && is_hit(pins_i.ad, pins_i.cbe, idsel, cmd[MEM_EN])) begin
          next_t = T_DEC;
          next_t_rd = !pins_i.cbe[0];
          next_t_cfg = pins_i.cbe[3];
          next_t_idx = pins_i.ad[7:2];
        end
      end
      T_DEC: begin
        next_t = T_DATA;
        if (!t_cfg) next_t_rdata = mem[t_idx[1:0]];
        else if (t_idx == CFG_ID) next_t_rdata = ID_VALUE;
        else if (t_idx == CFG_CMD) next_t_rdata = {sts, cmd};
        else next_t_rdata = 32'h0;
      end
      T_DATA: begin
        if (!pins_i.irdy_n) begin
          t_rx = !t_rd;
          if (!t_rd && !t_cfg) begin
            next_mem[t_idx[1:0]] = merge_be(mem[t_idx[1:0]], pins_i.ad, pins_i.cbe);
          end
          if (!t_rd && t_cfg && t_idx == CFG_CMD) begin
            next_cmd = (wr_keep[15:0] & CMD_WMASK) | (cmd & ~CMD_WMASK);
            sts_clr = wr_ones[31:16];
          end
          // single-phase target: stop goes with trdy, so bursts end here
          next_t = pins_i.frame_n ? T_TURN : T_HOLD;
        end
      end
      T_HOLD: begin
        if (pins_i.frame_n) next_t = T_TURN;
      end
      T_TURN: next_t = T_IDLE;
      default: next_t = T_IDLE;
    endcase
    sts_set = 16'h0000;
    sts_set[ST_DPE] = ev_dpe;
    sts_set[ST_SSE] = ev_sse;
    sts_set[ST_RMA] = ev_rma;
    sts_set[ST_RTA] = ev_rta;
    // set beats a same-cycle write-one clear
    next_sts = (sts & ~sts_clr) | sts_set;
  end

  always_ff @(posedge clk) begin
    if (pci_bus_reset) begin
      t_st <= T_IDLE;
      t_rd <= 1'b0;
      t_cfg <= 1'b0;
      t_idx <= 6'h00;
      t_rdata <= 32'h0;
      cmd <= CMD_RESET;
      sts <= STS_RESET;
      frame_d <= 1'b1;
    end else begin
      t_st <= next_t;
      t_rd <= next_t_rd;
      t_cfg <= next_t_cfg;
      t_idx <= next_t_idx;
      t_rdata <= next_t_rdata;
      cmd <= next_cmd;
      sts <= next_sts;
      frame_d <= pins_i.frame_n;
    end
    mem <= next_mem;
  end

  // ****************************************
  // initiator
  // ****************************************
  always_comb begin
    next_m = m_st;
    next_m_req = m_req;
    next_m_cnt = m_cnt;
    next_done = 1'b0;
    next_res = mst_result;
    next_rdata = mst_rdata;
    m_rx = 1'b0;
    ev_rma = 1'b0;
    ev_rta = 1'b0;
    case (m_st)
      M_IDLE: begin
        if (mst_start && cmd[MST_EN]) begin
          next_m = M_REQ;
          next_m_req = mst_cmd;
        end
      end
      M_REQ: begin
        // a parked grant with nothing pending simply starts nothing
        if (!gnt_n && bus_idle && t_st == T_IDLE) next_m = M_ADDR;
      end
      M_ADDR: begin
        next_m = M_DATA;
        next_m_cnt = 3'h0;
      end
      M_DATA: begin
        if (m_cnt != ABORT_CLKS) next_m_cnt = m_cnt + 3'h1;
        if (!pins_i.devsel_n && !pins_i.trdy_n) begin
          next_m = M_TURN;
          next_res = RES_OK;
          next_rdata = pins_i.ad;
          m_rx = !m_req.write;
        end else if (!pins_i.stop_n) begin
          next_m = M_TURN;
          next_res = pins_i.devsel_n ? RES_TABORT : RES_RETRY;
          ev_rta = pins_i.devsel_n;
        end else if (pins_i.devsel_n && m_cnt == ABORT_CLKS) begin
          next_m = M_TURN;
          next_res = RES_MABORT;
          ev_rma = 1'b1;
        end
      end
      M_TURN: begin
        next_m = M_IDLE;
        next_done = 1'b1;
      end
      default: next_m = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (pci_bus_reset) begin
      m_st <= M_IDLE;
      m_req <= '0;
      m_cnt <= 3'h0;
      mst_busy <= 1'b0;
      mst_done <= 1'b0;
      mst_result <= RES_OK;
      mst_rdata <= 32'h0;
      req_n <= 1'b1;
    end else begin
      m_st <= next_m;
      m_req <= next_m_req;
      m_cnt <= next_m_cnt;
      mst_busy <= next_m != M_IDLE;
      mst_done <= next_done;
      mst_result <= next_res;
      mst_rdata <= next_rdata;
      req_n <= next_m != M_REQ;
    end
  end

  // ****************************************
  // parity, errors and pin drivers
  // ****************************************
  always_comb begin
    next_dp_chk = t_rx || m_rx;
    next_dp_par = ^{pins_i.ad, pins_i.cbe};
    next_ap_chk = addr_phase;
    dp_bad = dp_chk && pins_i.par != dp_par;
    ap_bad = ap_chk && pins_i.par != ap_par;
    ev_dpe = dp_bad || ap_bad;
    if (dp_bad && cmd[PERR_EN]) next_perr_ph = 2'h2;
    else next_perr_ph = (perr_ph == 2'h2) ? 2'h1 : 2'h0;
    // a second event during the pulse is dropped, keeping it one clock wide
    next_serr = cmd[SERR_EN] && !serr_oe
      && ((ap_bad && cmd[PERR_EN]) || cb_addr_perr);
    ev_sse = next_serr;
    next_o = '1;
    next_oe = '0;
    next_o.ad = 32'h0;
    if (next_t != T_IDLE) begin
      next_oe.devsel_n = 1'b1;
      next_oe.trdy_n = 1'b1;
      next_oe.stop_n = 1'b1;
      next_o.devsel_n = next_t == T_TURN;
      next_o.trdy_n = next_t != T_DATA;
      next_o.stop_n = !(next_t == T_DATA || next_t == T_HOLD);
    end
    if (next_t == T_DATA && next_t_rd) begin
      next_o.ad = next_t_rdata;
      next_oe.ad = '1;
    end
    if (next_m == M_ADDR) begin
      next_o.frame_n = 1'b0;
      next_oe.frame_n = 1'b1;
      next_o.ad = next_m_req.addr;
      next_oe.ad = '1;
      next_o.cbe = next_m_req.write ? CMD_MWR : CMD_MRD;
      next_oe.cbe = '1;
    end
    if (next_m == M_DATA) begin
      next_oe.frame_n = 1'b1;
      next_o.irdy_n = 1'b0;
      next_oe.irdy_n = 1'b1;
      next_o.cbe = next_m_req.be_n;
      next_oe.cbe = '1;
      if (next_m_req.write) begin
        next_o.ad = next_m_req.data;
        next_oe.ad = '1;
      end
    end
    if (next_m == M_TURN) next_oe.irdy_n = 1'b1;
    next_o.par = ^{pins_o.ad, cbe_bus};
    next_oe.par = pins_oe.ad[0];
    next_o.perr_n = next_perr_ph != 2'h2;
    next_oe.perr_n = next_perr_ph != 2'h0;
  end

  always_ff @(posedge clk) begin
    if (pci_bus_reset) begin
      pins_o <= '1;
      pins_oe <= '0;
      serr_oe <= 1'b0;
      dp_chk <= 1'b0;
      dp_par <= 1'b0;
      ap_chk <= 1'b0;
      ap_par <= 1'b0;
      perr_ph <= 2'h0;
    end else begin
      pins_o <= next_o;
      pins_oe <= next_oe;
      serr_oe <= next_serr;
      dp_chk <= next_dp_chk;
      dp_par <= next_dp_par;
      ap_chk <= next_ap_chk;
      ap_par <= next_dp_par;
      perr_ph <= next_perr_ph;
    end
    serr_o <= 1'b0;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (pci_bus_reset);

  par_lag_a: assert property (
    pins_oe.ad[0] |=> pins_oe.par && pins_o.par == ^{$past(pins_o.ad), $past(cbe_bus)})
    else $error("par not driven one clock after ad");
  perr_time_a: assert property (
    (dp_chk && pins_i.par != dp_par && cmd[PERR_EN])
    |=> (!pins_o.perr_n && pins_oe.perr_n) ##1 (pins_o.perr_n && pins_oe.perr_n))
    else $error("perr not pulsed after bad data parity");
  perr_gate_a: assert property (
    (pins_oe.perr_n && !pins_o.perr_n) |-> $past(cmd[PERR_EN]))
    else $error("perr driven while disabled");
  serr_pulse_a: assert property (serr_oe |=> !serr_oe)
    else $error("serr wider than one clock");
  serr_gate_a: assert property (serr_oe |-> $past(cmd[SERR_EN]))
    else $error("serr while disabled");
  serr_card_a: assert property (
    (cb_addr_perr && cmd[SERR_EN] && !serr_oe) |=> serr_oe)
    else $error("card address parity error not reported");
  claim_seq_a: assert property (
    (t_st == T_IDLE && addr_phase && is_hit(pins_i.ad, pins_i.cbe, idsel, cmd[MEM_EN]))
    |=> !pins_o.devsel_n ##1 (!pins_o.trdy_n && !pins_o.stop_n))
    else $error("decoded cycle not claimed");
  master_abort_a: assert property (
    (m_st == M_DATA && pins_i.devsel_n && pins_i.stop_n && m_cnt == ABORT_CLKS)
    |=> m_st == M_TURN ##1 (mst_done && mst_result == RES_MABORT))
    else $error("timeout did not abort");
  frame_last_a: assert property (
    m_st == M_ADDR |-> !pins_o.frame_n ##1 (pins_o.frame_n && !pins_o.irdy_n))
    else $error("frame not released on final phase");
  wait_hold_a: assert property (
    (t_st == T_DATA && pins_i.irdy_n) |=> (t_st == T_DATA && !pins_o.trdy_n))
    else $error("phase ended without irdy");
  req_on_a: assert property (m_st == M_REQ |-> !req_n)
    else $error("req missing while waiting");
  reset_off_a: assert property (disable iff (1'b0)
    pci_bus_reset |=> (pins_oe == '0 && !serr_oe))
    else $error("pin driven after reset");

  tgt_write_c: cover property (t_rx && !t_cfg);
  cfg_read_c: cover property (t_st == T_DATA && t_cfg && t_rd && !pins_i.irdy_n);
  mst_ok_c: cover property (mst_done && mst_result == RES_OK);
  mst_abort_c: cover property (mst_done && mst_result == RES_MABORT);
endmodule : pbtip_port
`default_nettype wire

// [test/pbtip_far_agent.sv]
// pbtip_far_agent: arbiter and one far target for the port's initiator cycles
`default_nettype none
module pbtip_far_agent
  import pbtip_pkg::*;
#(
  parameter int WAITS = 2,
  parameter logic [31:0] RDATA = 32'h5a3c_0f96
) (
  input wire logic clk, // bus clock
  input wire logic reset, // synchronous, active high
  input wire pbtip_bus_t bus, // resolved levels
  input wire logic req_n, // request from the port
  input wire logic park, // grant with no request
  input wire logic [2:0] mode, // 0 ok, 1 silent, 2 abort, 3 retry, 4 bad parity
  output logic gnt_n, // grant
  output pbtip_bus_t o, // driven levels
  output pbtip_bus_t oe, // drive enables
  output logic [31:0] wdata // last data written here
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  logic fr_q;
  logic wr;
  int k;
  // ****************************************
  // responder
  // ****************************************
  always_ff @(posedge clk) begin
    fr_q <= bus.frame_n;
    k <= k + 1;
    if (reset) begin
      ph <= 2'h0;
      o <= '1;
      oe <= '0;
      gnt_n <= 1'b1;
    end else begin
      gnt_n <= park ? 1'b0 : req_n;
      o.par <= ^{bus.ad, bus.cbe} ^ (mode == 3'h4);
      oe.par <= oe.ad[0];
      case (ph)
        2'h0: if (fr_q && !bus.frame_n && bus.ad[31:28] == 4'h8 && mode != 3'h1) begin
          ph <= 2'h1;
          wr <= bus.cbe[0];
          k <= 0;
        end
        2'h1: begin
          oe[3:1] <= 3'h7;
          oe.ad <= {32{!wr}};
          o.ad <= RDATA;
          o[3:1] <= {mode[1] || k < WAITS, mode == 3'h2, !mode[1]};
          if (bus.frame_n && !bus.irdy_n && !(bus.trdy_n && bus.stop_n)) begin
            ph <= 2'h2;
            o[3:1] <= 3'h7;
            oe.ad <= '0;
            if (wr) begin
              wdata <= bus.ad;
            end
          end
        end
        default: begin
          oe[3:1] <= 3'h0;
          ph <= 2'h0;
        end
      endcase
    end
  end
endmodule : pbtip_far_agent
`default_nettype wire

// [test/pbtip_port_tb_top.sv]
// pbtip_port_tb_top: self-checking bench of the bus port
`default_nettype none
module pbtip_port_tb_top
  import pbtip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RDATA = 32'h5a3c_0f96;
  localparam logic [31:0] MEM = {MEM_BASE, 4'h8};
  logic clk = 1'b0;
  logic late = 1'b0;
  logic reset, idsel, gnt_n, req_n, serr_o, serr_oe, cb, start, busy, done, hit, park;
  pbtip_bus_t pins_i, pins_o, pins_oe, tb_o, tb_oe, m_o, m_oe, prev;
  pbtip_mreq_t mcmd;
  pbtip_res_t res;
  logic [31:0] rdata, wdata, rd;
  logic [2:0] mode;
  int n_errors, check_count, perr_cnt, serr_cnt, req_cnt, base;
  pbtip_port i_pbtip_port (.clk(clk), .pci_bus_reset(reset), .pins_i(pins_i), .pins_o(pins_o),
    .pins_oe(pins_oe), .idsel(idsel), .gnt_n(gnt_n), .req_n(req_n), .serr_o(serr_o),
    .serr_oe(serr_oe), .cb_addr_perr(cb), .mst_start(start), .mst_cmd(mcmd),
    .mst_busy(busy), .mst_done(done), .mst_result(res), .mst_rdata(rdata));
  pbtip_far_agent #(.RDATA(RDATA)) i_pbtip_far_agent (.clk(clk), .reset(reset), .bus(pins_i),
    .req_n(req_n), .park(park), .mode(mode), .gnt_n(gnt_n), .o(m_o), .oe(m_oe), .wdata(wdata));
  // ****************************************
  // wires, clock and monitors
  // ****************************************
  // undriven controls pull up; a released data line flips every cycle
  function automatic pbtip_bus_t res3(pbtip_bus_t a, ae, b, be, c, ce, p);
    return (a & ae) | (b & be) | (c & ce) | (~(ae | be | ce) & {~p[42:6], 6'h3f});
  endfunction : res3
  assign pins_i = res3(pins_o, pins_oe, m_o, m_oe, tb_o, tb_oe, prev);
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    prev <= pins_i;
    if (pins_oe.par) begin
      chk("par", ^{prev.ad, prev.cbe}, pins_i.par);
    end
    if (pins_oe.perr_n && !pins_i.perr_n) begin
      perr_cnt++;
    end
    if (serr_oe) begin
      serr_cnt++;
    end
    if (!req_n) begin
      req_cnt++;
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // single data phase as initiator; bad[0] spoils address parity, bad[1] data parity
  task automatic cyc(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
                     input logic [31:0] wd, input logic [3:0] be, input logic [1:0] bad);
    int n;
    n = 0;
    hit = 1'b0;
    @(negedge clk);
    tb_o.frame_n = 1'b0;
    tb_o.ad = a;
    tb_o.cbe = cmd;
    tb_oe[42:7] = '1;
    tb_oe[5:4] = 2'h3;
    idsel = sel;
    @(negedge clk);
    tb_o[6:4] = {^{a, cmd} ^ bad[0], 2'h2};
    tb_o.cbe = be;
    tb_o.ad = wd;
    tb_oe.ad = {32{cmd[0]}};
    tb_oe.par = 1'b1;
    idsel = 1'b0;
    // optional initiator wait states before the data is offered
    tb_o.irdy_n = late;
    if (late) begin
      repeat (3) @(negedge clk);
      tb_o.irdy_n = 1'b0;
    end
    do begin
      @(posedge clk);
      n++;
      hit |= !pins_i.devsel_n;
    end while (pins_i.trdy_n !== 1'b0 && n < 8);
    rd = pins_i.ad;
    @(negedge clk);
    tb_o.irdy_n = 1'b1;
    tb_o.par = ^{wd, be} ^ bad[1];
    tb_oe[42:7] = '0;
    tb_oe.par = cmd[0];
    tb_oe.frame_n = 1'b0;
    @(negedge clk);
    tb_oe = '0;
  endtask : cyc
  task automatic mst(input logic wr, input logic [31:0] d, input pbtip_res_t er);
    int n;
    n = 0;
    @(negedge clk);
    start = 1'b1;
    mcmd = '{wr, 32'h8000_0010, d, 4'h0};
    @(negedge clk);
    start = 1'b0;
    chk("busy", 1, busy);
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("done", 1, done);
    chk("result", 32'(er), 32'(res));
    if (!wr && er == RES_OK) begin
      chk("rdata", RDATA, rdata);
    end
  endtask : mst
  task automatic pulse_cb;
    @(negedge clk);
    cb = 1'b1;
    @(negedge clk);
    cb = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse_cb
  task automatic conclude;
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {reset, idsel, cb, start, park, mode, mcmd, tb_oe} = {5'h10, 3'h0, 69'h0, 43'h0};
    tb_o = '1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    chk("oe_rst", 0, {31'h0, |pins_oe});
    chk("req_rst", 1, req_n);
    cyc(CMD_CRD, 32'h0, 1, 0, 4'h0, 0);
    chk("id", ID_VALUE, rd);
    chk("claim", 1, hit);
    cyc(CMD_CRD, 32'h0, 0, 0, 4'h0, 0);
    chk("no_sel", 0, hit);
    cyc(CMD_CRD, 32'h4, 1, 0, 4'h0, 0);
    chk("cmd_rst", {STS_RESET, CMD_RESET}, rd);
    cyc(CMD_MRD, MEM, 0, 0, 4'h0, 0);
    chk("mem_off", 0, hit);
    cyc(CMD_CWR, 32'h4, 1, 32'h0000_ffff, 4'hd, 0);
    cyc(CMD_CRD, 32'h4, 1, 0, 4'h0, 0);
    chk("lane1", 32'h0000_0100, rd);
    cyc(CMD_CWR, 32'h4, 1, 32'h0000_ffff, 4'h0, 0);
    cyc(CMD_CRD, 32'h4, 1, 0, 4'h0, 0);
    chk("cmd_mask", {16'h0, CMD_WMASK}, rd);
    cyc(CMD_MWR, MEM, 0, 32'h1122_3344, 4'h0, 0);
    cyc(CMD_MWR, MEM, 0, 32'haabb_ccdd, 4'h5, 0);
    late = 1'b1;
    cyc(CMD_MRD, MEM, 0, 0, 4'h0, 0);
    late = 1'b0;
    chk("mem_be", 32'haa22_cc44, rd);
    base = perr_cnt;
    cyc(CMD_MWR, MEM, 0, 32'h1, 4'h0, 2'h2);
    repeat (4) @(negedge clk);
    chk("perr_on", base + 1, perr_cnt);
    cyc(CMD_CWR, 32'h4, 1, 32'h0000_0106, 4'h0, 0);
    base = perr_cnt;
    cyc(CMD_MWR, MEM, 0, 32'h1, 4'h0, 2'h2);
    repeat (4) @(negedge clk);
    chk("perr_off", base, perr_cnt);
    cyc(CMD_CRD, 32'h4, 1, 0, 4'h0, 0);
    chk("par_flag", 1, rd[31]);
    base = serr_cnt;
    pulse_cb();
    chk("serr_cb", base + 1, serr_cnt);
    chk("serr_lvl", 0, serr_o);
    cyc(CMD_CWR, 32'h4, 1, 32'h0000_0146, 4'h0, 0);
    base = serr_cnt;
    cyc(CMD_MRD, MEM, 0, 0, 4'h0, 2'h1);
    repeat (3) @(negedge clk);
    chk("serr_adr", base + 1, serr_cnt);
    cyc(CMD_CWR, 32'h4, 1, 32'h0000_0006, 4'h0, 0);
    base = serr_cnt;
    pulse_cb();
    chk("serr_off", base, serr_cnt);
    for (int i = 0; i < 4; i++) begin
      mode = 3'(i);
      mst(1'b1, 32'h1357_9bdf, pbtip_res_t'(i));
    end
    chk("req_seen", 1, req_cnt > 0);
    cyc(CMD_CRD, 32'h4, 1, 0, 4'h0, 0);
    chk("mab_flag", 1, rd[29]);
    chk("tab_flag", 1, rd[28]);
    mode = 3'h0;
    mst(1'b1, 32'h2468_ace0, RES_OK);
    chk("wdata", 32'h2468_ace0, wdata);
    mst(1'b0, 0, RES_OK);
    cyc(CMD_CWR, 32'h4, 1, 32'h0000_0146, 4'h0, 0);
    base = perr_cnt;
    mode = 3'h4;
    mst(1'b0, 0, RES_OK);
    repeat (4) @(negedge clk);
    chk("perr_rd", base + 1, perr_cnt);
    cyc(CMD_CWR, 32'h4, 1, 32'h0, 4'h0, 0);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    chk("mst_off", 0, busy);
    park = 1'b1;
    repeat (10) @(negedge clk);
    chk("park", 0, pins_oe.frame_n);
    chk("park_req", 1, req_n);
    park = 1'b0;
    conclude();
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : pbtip_port_tb_top
`default_nettype wire
